// ===== include/frd_pkg.sv
// Constants, types and opcode fields for the frame release and indexed offset decoder.
// Assumes a core that presents one fetched instruction word per instruction cycle.
package frd_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned PTR_W  = 12;
  localparam int unsigned LIT_W  = 6;
  localparam int unsigned FILE_W = 8;
  localparam int unsigned BANK_W = 4;

  // ==========================================================
  // Instruction word field positions
  localparam int unsigned OPC_LSB  = 8;
  localparam int unsigned SEL_LSB  = 6;
  localparam int unsigned ACC_BIT  = 8;
  localparam int unsigned DEST_BIT = 9;

  // ==========================================================
  // Opcode fields
  // Upper byte only; the select bits below it pick the pointer
  localparam logic [7:0] OPC_PTR_SUB   = 8'hE9;
  localparam logic [1:0] SEL_RELEASE   = 2'h3;
  localparam logic [7:0] IDX_LIMIT     = 8'h5F;
  localparam logic [7:0] ACC_SPLIT     = 8'h80;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hF;
  localparam logic [PTR_W-1:0] PTR_RST = 12'h000;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    FRD_IDLE,
    FRD_NOP
  } frd_state_t;

  typedef struct packed {
    logic             valid;
    logic [PTR_W-1:0] addr;
    logic             dest_file;
    logic             indexed;
  } frd_dacc_t;

  typedef struct packed {
    logic             load;
    logic [PTR_W-1:0] pc_value;
  } frd_ret_t;

endpackage : frd_pkg

// ===== core/frd_decode.sv
// Decode and execute of pointer subtract, frame release and indexed literal offset addressing.
// Assumes the core asserts INSTR_VALID for one CLK per executed instruction cycle.
// Assumes IS_FILE_OP comes from the core's own decode on the same clock.
`timescale 1ns/1ps
module frd_decode
  import frd_pkg::*;
#(
  parameter int unsigned PW = PTR_W
) (
  input  wire logic             CLK,
  input  wire logic             SYS_RST,
  input  wire logic             INSTR_VALID,
  input  wire logic [15:0]      INSTR_WORD,
  input  wire logic             EXT_ENABLE,
  input  wire logic [BANK_W-1:0] BANK_SELECT_VALUE,
  input  wire logic [PW-1:0]    RETURN_STACK_TOP,
  input  wire logic             IS_FILE_OP,
  output frd_dacc_t             DATA_ACCESS,
  output frd_ret_t              RETURN_LOAD,
  output logic                  POP_STACK,
  output logic                  FORCE_NOP,
  output logic [PW-1:0]         FRAME_POINTER_ZERO,
  output logic [PW-1:0]         FRAME_POINTER_ONE,
  output logic [PW-1:0]         FRAME_POINTER_TWO
);

  // ==========================================================
  // Elaboration checks
  // Struct fields follow the package widths, so PW is tied to them
  // Bank and file fields are glued into one address, so they must fill it
  if (PW != PTR_W) begin : g_pw_check
    $error("frd_decode: PW must equal PTR_W");
  end
  if (BANK_W + FILE_W != PW) begin : g_map_check
    $error("frd_decode: bank and file fields must fill the pointer");
  end
  if (LIT_W >= PW) begin : g_lit_check
    $error("frd_decode: literal must be narrower than the pointer");
  end
  if (IDX_LIMIT >= ACC_SPLIT) begin : g_idx_check
    $error("frd_decode: indexed range must stay in the low access half");
  end

  // ==========================================================
  // Field extraction
  logic              is_ptr_sub;
  logic              is_release;
  logic [1:0]        ptr_sel;
  logic [LIT_W-1:0]  lit;
  logic              acc_sel;
  logic              dest_sel;
  logic [FILE_W-1:0] fop;

  assign is_ptr_sub = (INSTR_WORD[OPC_LSB +: 8] == OPC_PTR_SUB);
  assign ptr_sel    = INSTR_WORD[SEL_LSB +: 2];
  assign lit        = INSTR_WORD[LIT_W-1:0];
  assign acc_sel    = INSTR_WORD[ACC_BIT];
  assign dest_sel   = INSTR_WORD[DEST_BIT];
  assign fop        = INSTR_WORD[FILE_W-1:0];
  assign is_release = is_ptr_sub && (ptr_sel == SEL_RELEASE);

  // ==========================================================
  // Helpers
  // Borrow beyond the top bit is dropped on purpose
  function automatic logic [PW-1:0] ptr_minus(input logic [PW-1:0] p,
                                               input logic [LIT_W-1:0] k);
    ptr_minus = p - {{(PW-LIT_W){1'b0}}, k};
  endfunction : ptr_minus

  // Zero extension of a file operand
  function automatic logic [PW-1:0] file_ext(input logic [FILE_W-1:0] f);
    file_ext = {{(PW-FILE_W){1'b0}}, f};
  endfunction : file_ext

  // Low access half in bank zero, high half in the top bank
  function automatic logic [PW-1:0] access_map(input logic [FILE_W-1:0] f);
    if (f < ACC_SPLIT) begin
      access_map = file_ext(f);
    end else begin
      access_map = {ACC_HIGH_BANK, f};
    end
  endfunction : access_map

  // Operand read as an offset from pointer two
  function automatic logic idx_hit(input logic              ext,
                                   input logic              a,
                                   input logic [FILE_W-1:0] f);
    idx_hit = ext && !a && (f <= IDX_LIMIT);
  endfunction : idx_hit

  // ==========================================================
  // Release sequence state
  frd_state_t state_ff;
  frd_state_t nxt_state;
  frd_ret_t   ret_ff;
  frd_ret_t   nxt_ret;
  logic       pop_ff;
  logic       nxt_pop;
  logic       take;

  assign take = INSTR_VALID && (state_ff == FRD_IDLE);

  always_comb begin
    nxt_state = state_ff;
    nxt_ret   = '0;
    nxt_pop   = 1'b0;
    case (state_ff)
      FRD_IDLE: begin
        if (take && is_release) begin
          nxt_ret.load     = 1'b1;
          nxt_ret.pc_value = RETURN_STACK_TOP;
          nxt_pop          = 1'b1;
          nxt_state        = FRD_NOP;
        end
      end
      FRD_NOP: begin
        // Swallowed cycle: no pointer update, no data access
        if (INSTR_VALID) begin
          nxt_state = FRD_IDLE;
        end
      end
      default: nxt_state = FRD_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_ff <= FRD_IDLE;
      ret_ff   <= '0;
      pop_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ret_ff   <= nxt_ret;
      pop_ff   <= nxt_pop;
    end
  end

  // ==========================================================
  // Pointer file
  // No status flags live here, so a subtract never touches any
  logic [PW-1:0] fp0_ff;
  logic [PW-1:0] fp1_ff;
  logic [PW-1:0] fp2_ff;
  logic [PW-1:0] nxt_fp0;
  logic [PW-1:0] nxt_fp1;
  logic [PW-1:0] nxt_fp2;

  always_comb begin
    nxt_fp0 = fp0_ff;
    nxt_fp1 = fp1_ff;
    nxt_fp2 = fp2_ff;
    if (take && is_ptr_sub) begin
      case (ptr_sel)
        2'h0: nxt_fp0 = ptr_minus(fp0_ff, lit);
        2'h1: nxt_fp1 = ptr_minus(fp1_ff, lit);
        default: nxt_fp2 = ptr_minus(fp2_ff, lit);
      endcase
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      fp0_ff <= PTR_RST;
      fp1_ff <= PTR_RST;
      fp2_ff <= PTR_RST;
    end else begin
      fp0_ff <= nxt_fp0;
      fp1_ff <= nxt_fp1;
      fp2_ff <= nxt_fp2;
    end
  end

  // ==========================================================
  // Operand classification
  // Only taken file instructions count; the swallowed cycle is ignored
  logic file_take;
  logic idx_now;

  assign file_take = take && IS_FILE_OP;
  assign idx_now   = idx_hit(EXT_ENABLE, acc_sel, fop);

  // ==========================================================
  // Effective data address
  // Uses the pointer before this cycle's update
  frd_dacc_t acc_ff;
  frd_dacc_t nxt_acc;

  always_comb begin
    nxt_acc           = '0;
    nxt_acc.dest_file = dest_sel;
    if (file_take) begin
      nxt_acc.valid = 1'b1;
      if (idx_now) begin
        // Pointer at zero yields the plain access map
        nxt_acc.indexed = 1'b1;
        nxt_acc.addr    = fp2_ff + file_ext(fop);
      end else if (!acc_sel) begin
        nxt_acc.addr = access_map(fop);
      end else begin
        nxt_acc.addr = {BANK_SELECT_VALUE, fop};
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      acc_ff <= '0;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // ==========================================================
  // Outputs
  assign DATA_ACCESS        = acc_ff;
  assign RETURN_LOAD        = ret_ff;
  assign POP_STACK          = pop_ff;
  assign FORCE_NOP          = (state_ff == FRD_NOP);
  assign FRAME_POINTER_ZERO = fp0_ff;
  assign FRAME_POINTER_ONE  = fp1_ff;
  assign FRAME_POINTER_TWO  = fp2_ff;

endmodule : frd_decode

// ===== bench/frd_decode_properties.sv
// Checker of release timing, pointer arithmetic and operand addressing.
// Assumes it is bound to frd_decode and sees only its ports.
`timescale 1ns/1ps
module frd_props
  import frd_pkg::*;
#(
  parameter int unsigned PW = PTR_W
) (
  input wire logic              CLK,
  input wire logic              SYS_RST,
  input wire logic              INSTR_VALID,
  input wire logic              EXT_ENABLE,
  input wire logic              IS_FILE_OP,
  input wire logic              POP_STACK,
  input wire logic              FORCE_NOP,
  input wire logic [15:0]       INSTR_WORD,
  input wire logic [BANK_W-1:0] BANK_SELECT_VALUE,
  input wire logic [PW-1:0]     RETURN_STACK_TOP,
  input wire logic [PW-1:0]     FRAME_POINTER_ZERO,
  input wire logic [PW-1:0]     FRAME_POINTER_ONE,
  input wire logic [PW-1:0]     FRAME_POINTER_TWO,
  input wire frd_dacc_t         DATA_ACCESS,
  input wire frd_ret_t          RETURN_LOAD
);
  // ========================================
  // Taken instruction classes
  wire tk  = INSTR_VALID && !FORCE_NOP;
  wire rel = tk && INSTR_WORD[15:6] == 10'h3A7;
  wire fop = tk && IS_FILE_OP;
  wire idx = fop && EXT_ENABLE && !INSTR_WORD[8] && INSTR_WORD[7:0] <= IDX_LIMIT;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_release_pop: assert property (rel |=> RETURN_LOAD.load && POP_STACK && FORCE_NOP)
    else $error("release did not pop");
  a_release_sub: assert property (rel |=> FRAME_POINTER_TWO ==
    $past(FRAME_POINTER_TWO) - $past(INSTR_WORD[5:0])
    && RETURN_LOAD.pc_value == $past(RETURN_STACK_TOP)) else $error("release result wrong");
  a_no_load: assert property (!rel |=> !RETURN_LOAD.load && !POP_STACK)
    else $error("stray return load");
  a_nop_swallow: assert property (INSTR_VALID && FORCE_NOP |=>
    !DATA_ACCESS.valid && !FORCE_NOP && $stable(FRAME_POINTER_TWO)) else $error("no-op acted");
  a_idx_addr: assert property (idx |=> DATA_ACCESS.indexed && DATA_ACCESS.addr ==
    $past(FRAME_POINTER_TWO) + $past(INSTR_WORD[7:0])) else $error("indexed address wrong");
  a_dest_keep: assert property (fop |=> DATA_ACCESS.valid
    && DATA_ACCESS.dest_file == $past(INSTR_WORD[9])) else $error("destination wrong");
  a_bank_addr: assert property (fop && INSTR_WORD[8] |=> !DATA_ACCESS.indexed
    && DATA_ACCESS.addr == {$past(BANK_SELECT_VALUE), $past(INSTR_WORD[7:0])})
    else $error("bank address wrong");
  a_access_addr: assert property (fop && !INSTR_WORD[8] && !idx |=>
    !DATA_ACCESS.indexed && DATA_ACCESS.addr ==
    {($past(INSTR_WORD[7]) ? ACC_HIGH_BANK : 4'h0), $past(INSTR_WORD[7:0])})
    else $error("access address wrong");
  a_sub_sel: assert property (tk && INSTR_WORD[15:6] == 10'h3A4 |=>
    FRAME_POINTER_ZERO == $past(FRAME_POINTER_ZERO) - $past(INSTR_WORD[5:0])
    && $stable(FRAME_POINTER_TWO)) else $error("select 0 subtract wrong");
  c_release: cover property (rel);
  c_indexed: cover property (idx);
  c_nop: cover property (INSTR_VALID && FORCE_NOP);
endmodule : frd_props

bind frd_decode frd_props #(.PW(PW)) u_props (.CLK, .SYS_RST, .INSTR_VALID, .EXT_ENABLE,
  .IS_FILE_OP, .POP_STACK, .FORCE_NOP, .INSTR_WORD, .BANK_SELECT_VALUE, .RETURN_STACK_TOP,
  .FRAME_POINTER_ZERO, .FRAME_POINTER_ONE, .FRAME_POINTER_TWO, .DATA_ACCESS, .RETURN_LOAD);

// ===== bench/frd_decode_bench.sv
// Directed bench for the frame release and indexed offset decoder.
// Assumes the checker arrives by its own bind.
`timescale 1ns/1ps
module frd_decode_bench;
  import frd_pkg::*;
  logic        CLK = 1'b0, SYS_RST = 1'b1, INSTR_VALID = 1'b0, EXT_ENABLE = 1'b0;
  logic        IS_FILE_OP = 1'b0, POP_STACK, FORCE_NOP;
  logic [15:0] INSTR_WORD = 16'h0000;
  logic [3:0]  BANK_SELECT_VALUE = 4'h3;
  logic [11:0] RETURN_STACK_TOP = 12'h5A1, FRAME_POINTER_ZERO, FRAME_POINTER_ONE;
  logic [11:0] FRAME_POINTER_TWO;
  frd_dacc_t   DATA_ACCESS;
  frd_ret_t    RETURN_LOAD;
  int          bad_count = 0, n_tests = 0;
  always #20 CLK = ~CLK;
  frd_decode dut (.CLK, .SYS_RST, .INSTR_VALID, .INSTR_WORD, .EXT_ENABLE, .BANK_SELECT_VALUE,
    .RETURN_STACK_TOP, .IS_FILE_OP, .DATA_ACCESS, .RETURN_LOAD, .POP_STACK, .FORCE_NOP,
    .FRAME_POINTER_ZERO, .FRAME_POINTER_ONE, .FRAME_POINTER_TWO);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Answer is one cycle wide, so sample just after the taking edge
  task automatic issue(input logic [15:0] w, input logic f);
    @(posedge CLK);
    INSTR_VALID <= 1'b1;
    INSTR_WORD  <= w;
    IS_FILE_OP  <= f;
    @(posedge CLK);
    INSTR_VALID <= 1'b0;
    #1;
  endtask : issue
  task automatic acc(input logic [15:0] w, input logic [15:0] e);
    issue(w, 1'b1);
    chk({DATA_ACCESS.valid, DATA_ACCESS.indexed, DATA_ACCESS.dest_file, 1'b0,
      DATA_ACCESS.addr}, e);
  endtask : acc
  task automatic t_low_map;
    chk({FORCE_NOP, 3'h0, FRAME_POINTER_ZERO | FRAME_POINTER_ONE | FRAME_POINTER_TWO}, 16'h0);
    @(posedge CLK);
    EXT_ENABLE <= 1'b1;
    acc(16'h242C, 16'hC02C);
  endtask : t_low_map
  task automatic t_subtract;
    issue(16'hE901, 1'b0);
    issue(16'hE942, 1'b0);
    issue(16'hE981, 1'b0);
    chk({4'h0, FRAME_POINTER_ZERO}, 16'h0FFF);
    chk({4'h0, FRAME_POINTER_ONE}, 16'h0FFE);
    chk({4'h0, FRAME_POINTER_TWO}, 16'h0FFF);
  endtask : t_subtract
  task automatic t_release;
    issue(16'hE9E3, 1'b0);
    chk({RETURN_LOAD.load, POP_STACK, FORCE_NOP, 1'b0, RETURN_LOAD.pc_value}, 16'hE5A1);
    chk({4'h0, FRAME_POINTER_TWO}, 16'h0FDC);
    issue(16'h2410, 1'b1);
    chk({DATA_ACCESS.valid, RETURN_LOAD.load, POP_STACK, FORCE_NOP, FRAME_POINTER_TWO},
      16'h0FDC);
  endtask : t_release
  task automatic t_access;
    acc(16'h2630, 16'hE00C);
    acc(16'h245F, 16'hC03B);
    acc(16'h2460, 16'h8060);
    acc(16'h2510, 16'h8310);
    acc(16'h24A0, 16'h8FA0);
    @(posedge CLK);
    EXT_ENABLE <= 1'b0;
    acc(16'h242C, 16'h802C);
  endtask : t_access
  task automatic results;
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  initial begin
    repeat (20) @(posedge CLK);
    SYS_RST <= 1'b0;
    t_low_map();
    t_subtract();
    t_release();
    t_access();
    results();
  end
endmodule : frd_decode_bench
